// ===== rtl/rtct_pkg.sv
// constants shared by the real time clock register block
package rtct_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int TOD_W  = 17;
    localparam int DAY_W  = 15;
    localparam int CAL_W  = 5;
    localparam int MODE_W = 2;
    localparam int SPARE_W = 6;

    // register addresses on the register access port
    localparam logic [ADDR_W-1:0] ADDR_TIME_OF_DAY = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_TIME_ALARM  = 6'h15;
    localparam logic [ADDR_W-1:0] ADDR_DAY_COUNT   = 6'h16;
    localparam logic [ADDR_W-1:0] ADDR_DAY_ALARM   = 6'h17;

    // field positions
    localparam int TOD_LSB   = 0;
    localparam int TOD_MSB   = 16;
    localparam int CAL_LSB   = 17;
    localparam int CAL_MSB   = 21;
    localparam int MODE_LSB  = 22;
    localparam int MODE_MSB  = 23;
    localparam int SPARE_LSB = 17;
    localparam int SPARE_MSB = 22;
    localparam int DIS_BIT   = 23;
    localparam int DAY_LSB   = 0;
    localparam int DAY_MSB   = 14;

    // reset values
    localparam logic [TOD_W-1:0]   TOD_RESET   = 17'h00000;
    localparam logic [CAL_W-1:0]   CAL_RESET   = 5'h00;
    localparam logic [MODE_W-1:0]  MODE_RESET  = 2'h0;
    localparam logic [TOD_W-1:0]   TIME_ALARM_VALUE_RESET  = 17'h1FFFF;
    localparam logic [SPARE_W-1:0] SPARE_RESET = 6'h00;
    localparam logic               DIS_RESET   = 1'b0;
    localparam logic [DAY_W-1:0]   DAY_RESET   = 15'h0000;
    localparam logic [DAY_W-1:0]   DAY_ALARM_VALUE_RESET  = 15'h7FFF;
    localparam logic [DATA_W-1:0]  READ_ZERO   = 24'h000000;

    // seconds in one day; time count wraps here and bumps the day
    localparam logic [TOD_W-1:0] SECONDS_PER_DAY = 17'h15180;

endpackage

// ===== rtl/rtct_count_if.sv
// carrier between register file and the time/day counter
`timescale 1ns/1ps
interface rtct_count_if;
    logic                          tick;
    logic                          run;
    logic                          tod_load;
    logic                          day_load;
    logic [rtct_pkg::TOD_W-1:0]    tod_value;
    logic [rtct_pkg::DAY_W-1:0]    day_value;
    logic [rtct_pkg::TOD_W-1:0]    time_of_day_count;
    logic [rtct_pkg::DAY_W-1:0]    day;

    modport ctrl (
        output tick,
        output run,
        output tod_load,
        output day_load,
        output tod_value,
        output day_value,
        input  time_of_day_count,
        input  day
    );
    modport counter (
        input  tick,
        input  run,
        input  tod_load,
        input  day_load,
        input  tod_value,
        input  day_value,
        output time_of_day_count,
        output day
    );
endinterface

// ===== rtl/rtct_counter.sv
// time-of-day and day counters with software load
`timescale 1ns/1ps
module rtct_counter #(
    parameter logic [rtct_pkg::TOD_W-1:0] DAY_LENGTH =
        rtct_pkg::SECONDS_PER_DAY
) (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // counter side of the carrier
    rtct_count_if.counter      cnt
);

    logic [rtct_pkg::TOD_W-1:0] time_of_day_count;
    logic [rtct_pkg::DAY_W-1:0] day;
    logic                       wrap;

    assign wrap = (time_of_day_count == DAY_LENGTH - 17'h00001);

    // a software load wins over a tick in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            time_of_day_count <= rtct_pkg::TOD_RESET;
        end else if (cnt.tod_load) begin
            time_of_day_count <= cnt.tod_value;
        end else if (cnt.run && cnt.tick) begin
            time_of_day_count <= wrap ? rtct_pkg::TOD_RESET : time_of_day_count + 17'h00001;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            day <= rtct_pkg::DAY_RESET;
        end else if (cnt.day_load) begin
            day <= cnt.day_value;
        end else if (cnt.run && cnt.tick && wrap && !cnt.tod_load) begin
            day <= day + 15'h0001;
        end
    end

    assign cnt.time_of_day_count = time_of_day_count;
    assign cnt.day = day;

endmodule

// ===== rtl/rtct_registers.sv
// real time clock registers, alarm compare and register port
`timescale 1ns/1ps
module rtct_registers #(
    parameter logic [rtct_pkg::TOD_W-1:0] DAY_LENGTH =
        rtct_pkg::SECONDS_PER_DAY
) (
    // clock and clock-domain power-on reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    // one-second tick from logic on the same clock
    input  wire logic                        tick_in,
    // register access port
    input  wire logic [rtct_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    input  wire logic [rtct_pkg::DATA_W-1:0] reg_wdata_in,
    output logic      [rtct_pkg::DATA_W-1:0] reg_rdata_out,
    output logic                             reg_rvalid_out,
    // status and control towards the rest of the device
    output logic                             alarm_event_out,
    output logic                             clock_enabled_out,
    output logic      [rtct_pkg::CAL_W-1:0]  clock_calibration_count_out,
    output logic      [rtct_pkg::MODE_W-1:0] clock_calibration_select_out
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [rtct_pkg::CAL_W-1:0]   clock_calibration_count;
    logic [rtct_pkg::MODE_W-1:0]  clock_calibration_select;
    logic [rtct_pkg::TOD_W-1:0]   time_alarm_value;
    logic [rtct_pkg::SPARE_W-1:0] alarm_spare;
    logic                         clock_disable_bit;
    logic [rtct_pkg::DAY_W-1:0]   day_alarm_value;
    logic                         wr_time;
    logic                         wr_alarm;
    logic                         wr_day;
    logic                         wr_day_alarm;
    logic                         match;
    logic                         match_seen;
    logic [rtct_pkg::DATA_W-1:0]  next_rdata;

    rtct_count_if cnt_if ();

    assign wr_time      = reg_wr_in
                       && reg_addr_in == rtct_pkg::ADDR_TIME_OF_DAY;
    assign wr_alarm     = reg_wr_in
                       && reg_addr_in == rtct_pkg::ADDR_TIME_ALARM;
    assign wr_day       = reg_wr_in && reg_addr_in == rtct_pkg::ADDR_DAY_COUNT;
    assign wr_day_alarm = reg_wr_in && reg_addr_in == rtct_pkg::ADDR_DAY_ALARM;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clock_calibration_count  <= rtct_pkg::CAL_RESET;
            clock_calibration_select <= rtct_pkg::MODE_RESET;
        end else if (wr_time) begin
            clock_calibration_count <=
                reg_wdata_in[rtct_pkg::CAL_MSB:rtct_pkg::CAL_LSB];
            clock_calibration_select <=
                reg_wdata_in[rtct_pkg::MODE_MSB:rtct_pkg::MODE_LSB];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            time_alarm_value  <= rtct_pkg::TIME_ALARM_VALUE_RESET;
            alarm_spare       <= rtct_pkg::SPARE_RESET;
            clock_disable_bit <= rtct_pkg::DIS_RESET;
        end else if (wr_alarm) begin
            time_alarm_value <=
                reg_wdata_in[rtct_pkg::TOD_MSB:rtct_pkg::TOD_LSB];
            alarm_spare <=
                reg_wdata_in[rtct_pkg::SPARE_MSB:rtct_pkg::SPARE_LSB];
            clock_disable_bit <= reg_wdata_in[rtct_pkg::DIS_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            day_alarm_value <= rtct_pkg::DAY_ALARM_VALUE_RESET;
        end else if (wr_day_alarm) begin
            day_alarm_value <=
                reg_wdata_in[rtct_pkg::DAY_MSB:rtct_pkg::DAY_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counters

    assign cnt_if.tick      = tick_in;
    assign cnt_if.run       = !clock_disable_bit;
    assign cnt_if.tod_load  = wr_time;
    assign cnt_if.day_load  = wr_day;
    assign cnt_if.tod_value =
        reg_wdata_in[rtct_pkg::TOD_MSB:rtct_pkg::TOD_LSB];
    assign cnt_if.day_value =
        reg_wdata_in[rtct_pkg::DAY_MSB:rtct_pkg::DAY_LSB];

    rtct_counter #(
        .DAY_LENGTH (DAY_LENGTH)
    ) u_counter (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .cnt      (cnt_if.counter)
    );

    ////////////////////////////////////////////////////////////////////////
    // alarm compare

    // edge of the match so a held match gives one event, not a stream
    assign match = !clock_disable_bit
                && cnt_if.time_of_day_count == time_alarm_value
                && cnt_if.day == day_alarm_value;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_seen      <= 1'b0;
            alarm_event_out <= 1'b0;
        end else begin
            match_seen      <= match;
            alarm_event_out <= match && !match_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port; unused upper bits and unmapped addresses read zero

    always_comb begin
        next_rdata = rtct_pkg::READ_ZERO;
        case (reg_addr_in)
            rtct_pkg::ADDR_TIME_OF_DAY: begin
                next_rdata = {clock_calibration_select,
                              clock_calibration_count, cnt_if.time_of_day_count};
            end
            rtct_pkg::ADDR_TIME_ALARM: begin
                next_rdata = {clock_disable_bit, alarm_spare,
                              time_alarm_value};
            end
            rtct_pkg::ADDR_DAY_COUNT: begin
                next_rdata[rtct_pkg::DAY_MSB:rtct_pkg::DAY_LSB] =
                    cnt_if.day;
            end
            rtct_pkg::ADDR_DAY_ALARM: begin
                next_rdata[rtct_pkg::DAY_MSB:rtct_pkg::DAY_LSB] =
                    day_alarm_value;
            end
            default: begin
                next_rdata = rtct_pkg::READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out  <= rtct_pkg::READ_ZERO;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clock_enabled_out            <= 1'b0;
            clock_calibration_count_out  <= rtct_pkg::CAL_RESET;
            clock_calibration_select_out <= rtct_pkg::MODE_RESET;
        end else begin
            clock_enabled_out            <= !clock_disable_bit;
            clock_calibration_count_out  <= clock_calibration_count;
            clock_calibration_select_out <= clock_calibration_select;
        end
    end

endmodule

// ===== testbench/rtct_props.sv
// assertion checker for the real time clock register block
`timescale 1ns/1ps
module rtct_props (
    // clock and reset
    input wire logic                        clk_in,
    input wire logic                        rst_n_in,
    // inputs
    input wire logic                        tick_in,
    input wire logic [rtct_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic                        reg_wr_in,
    input wire logic                        reg_rd_in,
    input wire logic [rtct_pkg::DATA_W-1:0] reg_wdata_in,
    // outputs
    input wire logic [rtct_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic                        reg_rvalid_out,
    input wire logic                        alarm_event_out,
    input wire logic                        clock_enabled_out,
    input wire logic [rtct_pkg::CAL_W-1:0]  clock_calibration_count_out,
    input wire logic [rtct_pkg::MODE_W-1:0] clock_calibration_select_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    sequence s_wr(a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    a_read_answers: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered next cycle");
    a_valid_one_cycle: assert property (!reg_rd_in
        |=> !reg_rvalid_out) else $error("read valid without read");
    a_day_top_zero: assert property (s_rd(rtct_pkg::ADDR_DAY_COUNT)
        |=> reg_rdata_out[23:15] == 9'h000) else $error("day top bits set");
    a_dalarm_top_zero: assert property (s_rd(rtct_pkg::ADDR_DAY_ALARM)
        |=> reg_rdata_out[23:15] == 9'h000) else $error("alarm top set");
    a_cal_export: assert property (reg_rvalid_out &&
        $past(reg_addr_in) == rtct_pkg::ADDR_TIME_OF_DAY |->
        reg_rdata_out[21:17] == clock_calibration_count_out &&
        reg_rdata_out[23:22] == clock_calibration_select_out)
        else $error("calibration export differs from register");
    a_disable_level: assert property (s_wr(rtct_pkg::ADDR_TIME_ALARM)
        |=> ##1 clock_enabled_out == !$past(reg_wdata_in[23], 2))
        else $error("enable output does not follow disable bit");
    a_alarm_pulse: assert property (alarm_event_out
        |=> !alarm_event_out)
        else $error("alarm event longer than one cycle");
    a_alarm_enabled: assert property (alarm_event_out
        |-> clock_enabled_out)
        else $error("alarm event while disabled");
endmodule
bind rtct_registers rtct_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tick_in(tick_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .alarm_event_out(alarm_event_out), .clock_enabled_out(clock_enabled_out),
    .clock_calibration_count_out(clock_calibration_count_out),
    .clock_calibration_select_out(clock_calibration_select_out));

// ===== testbench/tb.sv
// self-checking testbench for the real time clock register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    logic                        clk_in = 1'b0;
    logic                        rst_n_in = 1'b0;
    logic                        tick = 1'b0;
    logic [rtct_pkg::ADDR_W-1:0] addr = 6'h00;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic [rtct_pkg::DATA_W-1:0] wdata = 24'h000000;
    logic [rtct_pkg::DATA_W-1:0] rdata;
    logic                        rvalid;
    logic                        alarm;
    logic                        enabled;
    logic [rtct_pkg::CAL_W-1:0]  cal;
    logic [rtct_pkg::MODE_W-1:0] sel;
    int                          bad_count = 0;
    int                          checked = 0;
    int                          cycles = 0;
    int                          events = 0;
    // short day so rollover is reached in a handful of ticks
    rtct_registers #(.DAY_LENGTH(17'h00004)) uut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .tick_in(tick), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .alarm_event_out(alarm), .clock_enabled_out(enabled),
        .clock_calibration_count_out(cal),
        .clock_calibration_select_out(sel));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk_in) begin
        cycles++;
        events += (alarm === 1'b1);
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    // strobe stands for one edge, then an idle edge passes so that a
    // following call never re-raises a strobe in the same time step
    task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
        @(negedge clk_in);
    endtask
    // rvalid stands for the one cycle after the strobe edge: look there
    task automatic rd_reg(input logic [5:0] a, input logic [23:0] e);
        addr = a;
        rd   = 1'b1;
        @(negedge clk_in);
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", e, rdata)
        rd = 1'b0;
        @(negedge clk_in);
    endtask
    task automatic pulse_tick();
        tick = 1'b1;
        @(negedge clk_in);
        tick = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic do_reset();
        rst_n_in = 1'b0;
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        rd_reg(6'h14, 24'h000000);
        rd_reg(6'h15, 24'h01FFFF);
        rd_reg(6'h16, 24'h000000);
        rd_reg(6'h17, 24'h007FFF);
        `CHK("enabled", 1'b1, enabled)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        wr_reg(6'h14, 24'hFFFFFF);
        rd_reg(6'h14, 24'hFFFFFF);
        `CHK("cal", 5'h1F, cal)
        `CHK("sel", 2'h3, sel)
        wr_reg(6'h15, 24'h7FFFFF);
        rd_reg(6'h15, 24'h7FFFFF);
        // all-ones time and day now equal both alarms: one event expected
        wr_reg(6'h16, 24'hFFFFFF);
        rd_reg(6'h16, 24'h007FFF);
        `CHK("events", 1, events)
        wr_reg(6'h17, 24'hFFFFFF);
        rd_reg(6'h17, 24'h007FFF);
        wr_reg(6'h18, 24'hFFFFFF);
        rd_reg(6'h18, 24'h000000);
        // alarm at second 2 of day 1; four seconds make a day here
        wr_reg(6'h14, 24'h000000);
        wr_reg(6'h16, 24'h000000);
        wr_reg(6'h17, 24'h000001);
        wr_reg(6'h15, 24'h000002);
        for (int i = 1; i <= 7; i++) begin
            pulse_tick();
            `CHK("events", (i >= 6) ? 2 : 1, events)
        end
        rd_reg(6'h14, 24'h000003);
        rd_reg(6'h16, 24'h000001);
        wr_reg(6'h15, 24'h800002);
        @(negedge clk_in);
        `CHK("enabled", 1'b0, enabled)
        pulse_tick();
        rd_reg(6'h14, 24'h000003);
        // second reset in mid-run must restore every default
        do_reset();
        conclude();
    end
endmodule
